// >>> rtl/charge_attach_pkg.sv
// shared constants, types and register map of the charge/attach indicator control
// assumes a single 50 MHz clock and an AXI4-Lite master for software access
package charge_attach_pkg;

    // clock and timebase
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_NS = 1000000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

    // timed behaviour, counted in timebase ticks of one millisecond
    localparam int unsigned TICK_MS = TICK_NS / 1000000;
    localparam int unsigned ATTACH_HOLD_S = 25;
    localparam int unsigned ATTACH_HOLD_TICKS = ATTACH_HOLD_S * 1000 / TICK_MS;
    localparam int unsigned SAFETY_HOURS = 3;
    localparam int unsigned SAFETY_TICKS = SAFETY_HOURS * 3600 * 1000 / TICK_MS;
    localparam int unsigned DEGLITCH_MS = 8;
    localparam int unsigned DEGLITCH_TICKS = DEGLITCH_MS / TICK_MS;

    // register map, byte addresses
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] STATUS_OFS = 8'h00;
    localparam logic [AXI_AW-1:0] IRQ_STATUS_OFS = 8'h04;
    localparam logic [AXI_AW-1:0] IRQ_MASK_OFS = 8'h08;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // event bits of the interrupt status and mask registers
    localparam int IRQ_ATTACH_BIT = 0;
    localparam int IRQ_EXPIRED_BIT = 1;
    localparam int IRQ_FAULT_BIT = 2;
    localparam int IRQ_CHARGE_BIT = 3;

    // status register fields
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_FAULT_BIT = 1;
    localparam int ST_STOP_BIT = 2;
    localparam int ST_DETECT_BIT = 3;
    localparam int ST_CDPQUAL_BIT = 4;
    localparam int ST_MODE_LSB = 8;

    typedef enum logic [5:0] {
        MODE_OFF = 6'h01,
        MODE_CDP = 6'h02,
        MODE_SDP = 6'h04,
        MODE_DCP_AUTO = 6'h08,
        MODE_DCP_BC = 6'h10,
        MODE_DCP_DIV = 6'h20
    } mode_e;

    typedef enum logic [2:0] {
        SAFE_IDLE = 3'h1,
        SAFE_TIMING = 3'h2,
        SAFE_EXPIRED = 3'h4
    } safety_e;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

endpackage

// >>> rtl/charge_attach_indicator_control.sv
// control and indication logic of a usb port charging controller
// assumes all pins synchronous to clk; analog comparators and detectors arrive as levels
// How it works
// - dedicated or charging-downstream mode pulls the flag while current exceeds threshold
// - charging-downstream flag needs the handshake done before current rose
// - sleeping battery host runs a three hour timer that stops charging
// - the safety timer starts only on a device attachment event
// - attach-detect enable low cancels the safety timer, running or not
// - flag releases on timeout or when current drops below threshold
// - attach detector runs only with attach enable high and enable low
// - an attachment pulls the flag for a 25 s hold, then releases
// - enable low turns off power switch, data switch and charger emulator
// - enable gates the attach detector, which runs only with enable low; attach enable governs it too
// - overcurrent, thermal and reverse-current events reach fault only after deglitch
// - flag pin is active-low open drain: pulls low or floats
// - 111 cdp, 110/010 sdp, 001 auto, 100 bc1.2, 101 divider
`timescale 1ns/1ps
`default_nettype none

module charge_attach_indicator_control
    import charge_attach_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES,
    parameter int unsigned HOLD_LEN = ATTACH_HOLD_TICKS,
    parameter int unsigned SAFETY_LEN = SAFETY_TICKS,
    parameter int unsigned DEGLITCH_LEN = DEGLITCH_TICKS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire axi_req_s axiReq,
    output axi_rsp_s axiRsp,
    input wire logic enable,
    input wire logic profileSelect0,
    input wire logic profileSelect1,
    input wire logic profileSelect2,
    input wire logic attachEn,
    input wire logic currentAbove,
    input wire logic handshakeDone,
    input wire logic sleepS45,
    input wire logic hostOnBattery,
    input wire logic attachSense,
    input wire logic overCurrent,
    input wire logic thermalShutdown,
    input wire logic reverseCurrent,
    output logic chargeAttachOut,
    output logic chargeAttachOe,
    output logic faultOut,
    output logic faultOe,
    output logic powerSwitchOn,
    output logic dataSwitchOn,
    output logic emulatorOn,
    output logic attachDetectorOn,
    output logic chargeStop,
    output logic irq
);

    function automatic mode_e decodeProfile(input logic [2:0] sel);
        unique case (sel)
            3'h7: decodeProfile = MODE_CDP;
            3'h6, 3'h2: decodeProfile = MODE_SDP;
            3'h1: decodeProfile = MODE_DCP_AUTO;
            3'h4: decodeProfile = MODE_DCP_BC;
            3'h5: decodeProfile = MODE_DCP_DIV;
            default: decodeProfile = MODE_OFF;
        endcase
    endfunction

    // reset release through two flops; assertion stays asynchronous
    logic [1:0] rstSync_q;
    logic rstSync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstSync_b = rstSync_q[1];

    // profile decode and switch gating
    mode_e mode;
    logic isCdp, isDcp;
    assign mode = decodeProfile({profileSelect2, profileSelect1, profileSelect0});
    assign isCdp = (mode == MODE_CDP);
    assign isDcp = (mode == MODE_DCP_AUTO) || (mode == MODE_DCP_BC) || (mode == MODE_DCP_DIV);
    assign attachDetectorOn = attachEn && !enable;

    // millisecond timebase
    logic [31:0] tickCnt_q, tickCnt_d;
    logic tick;
    always_comb begin
        tick = (tickCnt_q == 32'(TICK_LEN - 1));
        tickCnt_d = tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
    end

    // attach detection and hold
    logic attachSense_q, attachEvent;
    logic [31:0] holdCnt_q, holdCnt_d;
    logic holdActive;
    always_comb begin
        attachEvent = attachDetectorOn && attachSense && !attachSense_q;
        holdActive = (holdCnt_q != 32'h0000_0000);
        holdCnt_d = holdCnt_q;
        if (attachEvent) begin
            holdCnt_d = 32'(HOLD_LEN);
        end else if (holdActive && tick) begin
            holdCnt_d = holdCnt_q - 32'h0000_0001;
        end
    end

    // charging-downstream handshake qualification
    logic cdpQual_q, cdpQual_d;
    always_comb begin
        cdpQual_d = cdpQual_q;
        if (!enable || !isCdp) begin
            cdpQual_d = 1'b0;
        end else if (handshakeDone && !currentAbove) begin
            cdpQual_d = 1'b1;
        end
    end

    // end-of-charge safety timer
    safety_e safe_q, safe_d;
    logic [31:0] safeCnt_q, safeCnt_d;
    logic safeAllowed;
    always_comb begin
        safeAllowed = attachEn && sleepS45 && hostOnBattery;
        safe_d = safe_q;
        safeCnt_d = safeCnt_q;
        unique case (safe_q)
            SAFE_IDLE: begin
                safeCnt_d = 32'h0000_0000;
                if (safeAllowed && attachEvent) begin
                    safe_d = SAFE_TIMING;
                end
            end
            SAFE_TIMING: begin
                if (!safeAllowed) begin
                    safe_d = SAFE_IDLE;
                end else if (safeCnt_q == 32'(SAFETY_LEN)) begin
                    safe_d = SAFE_EXPIRED;
                end else if (tick) begin
                    safeCnt_d = safeCnt_q + 32'h0000_0001;
                end
            end
            SAFE_EXPIRED: begin
                if (!safeAllowed) begin
                    safe_d = SAFE_IDLE;
                end
            end
            default: safe_d = SAFE_IDLE;
        endcase
    end
    assign chargeStop = (safe_q == SAFE_EXPIRED);
    assign powerSwitchOn = enable && !chargeStop;
    assign dataSwitchOn = enable;
    assign emulatorOn = enable && (mode != MODE_OFF);

    // indication flag; released by timeout or low current
    logic chargingReq, flag_q, flag_d;
    always_comb begin
        chargingReq = enable && currentAbove && !chargeStop
            && (isDcp || (isCdp && cdpQual_q));
        flag_d = chargingReq || holdActive || attachEvent;
    end
    assign chargeAttachOut = 1'b0;
    assign chargeAttachOe = flag_q;

    // fault deglitch: set only after a sustained event, release at once
    logic faultRaw, fault_q, fault_d;
    logic [31:0] faultCnt_q, faultCnt_d;
    always_comb begin
        faultRaw = overCurrent || thermalShutdown || reverseCurrent;
        faultCnt_d = faultCnt_q;
        fault_d = fault_q;
        if (!faultRaw) begin
            faultCnt_d = 32'h0000_0000;
            fault_d = 1'b0;
        end else if (faultCnt_q == 32'(DEGLITCH_LEN)) begin
            fault_d = 1'b1;
        end else if (tick) begin
            faultCnt_d = faultCnt_q + 32'h0000_0001;
        end
    end
    assign faultOut = 1'b0;
    assign faultOe = fault_q;

    // interrupt events; a set in the same cycle as a clear wins
    logic [3:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d, irqEvent;
    logic chargingReq_q;
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [AXI_AW-1:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rdata_q, rdata_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic doWrite, doRead;
    always_comb begin
        irqEvent = 4'h0;
        irqEvent[IRQ_ATTACH_BIT] = attachEvent;
        irqEvent[IRQ_EXPIRED_BIT] = (safe_q == SAFE_TIMING) && (safe_d == SAFE_EXPIRED);
        irqEvent[IRQ_FAULT_BIT] = fault_d && !fault_q;
        irqEvent[IRQ_CHARGE_BIT] = chargingReq && !chargingReq_q;
    end

    // axi4-lite slave: address and data taken in either order, one write and read at a time
    always_comb begin
        axiRsp.awready = !awHeld_q && !bvalid_q;
        axiRsp.wready = !wHeld_q && !bvalid_q;
        axiRsp.arready = !rvalid_q;
        axiRsp.bvalid = bvalid_q;
        axiRsp.bresp = bresp_q;
        axiRsp.rvalid = rvalid_q;
        axiRsp.rdata = rdata_q;
        axiRsp.rresp = rresp_q;
        doWrite = awHeld_q && wHeld_q && !bvalid_q;
        doRead = axiReq.arvalid && !rvalid_q;
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        irqMask_d = irqMask_q;
        irqStat_d = irqStat_q;
        if (axiReq.awvalid && axiRsp.awready) begin
            awHeld_d = 1'b1;
            awAddr_d = axiReq.awaddr;
        end
        if (axiReq.wvalid && axiRsp.wready) begin
            wHeld_d = 1'b1;
            wData_d = axiReq.wdata;
            wStrb_d = axiReq.wstrb;
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            unique case ({awAddr_q[AXI_AW-1:2], 2'h0})
                STATUS_OFS: ;
                IRQ_STATUS_OFS: begin
                    if (wStrb_q[0]) begin
                        irqStat_d = irqStat_q & ~wData_q[3:0];
                    end
                end
                IRQ_MASK_OFS: begin
                    if (wStrb_q[0]) begin
                        irqMask_d = wData_q[3:0];
                    end
                end
                default: bresp_d = RESP_SLVERR;
            endcase
        end
        irqStat_d = irqStat_d | irqEvent;
        if (bvalid_q && axiReq.bready) begin
            bvalid_d = 1'b0;
        end
        if (rvalid_q && axiReq.rready) begin
            rvalid_d = 1'b0;
        end
        if (doRead) begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case ({axiReq.araddr[AXI_AW-1:2], 2'h0})
                STATUS_OFS: begin
                    rdata_d[ST_FLAG_BIT] = flag_q;
                    rdata_d[ST_FAULT_BIT] = fault_q;
                    rdata_d[ST_STOP_BIT] = chargeStop;
                    rdata_d[ST_DETECT_BIT] = attachDetectorOn;
                    rdata_d[ST_CDPQUAL_BIT] = cdpQual_q;
                    rdata_d[ST_MODE_LSB +: 6] = mode;
                end
                IRQ_STATUS_OFS: rdata_d[3:0] = irqStat_q;
                IRQ_MASK_OFS: rdata_d[3:0] = irqMask_q;
                default: rresp_d = RESP_SLVERR;
            endcase
        end
    end
    assign irq = |(irqStat_q & irqMask_q);

    always_ff @(posedge clk or negedge rstSync_b) begin
        if (!rstSync_b) begin
            tickCnt_q <= 32'h0000_0000;
            attachSense_q <= 1'b0;
            holdCnt_q <= 32'h0000_0000;
            cdpQual_q <= 1'b0;
            safe_q <= SAFE_IDLE;
            safeCnt_q <= 32'h0000_0000;
            flag_q <= 1'b0;
            faultCnt_q <= 32'h0000_0000;
            fault_q <= 1'b0;
            chargingReq_q <= 1'b0;
            irqStat_q <= 4'h0;
            irqMask_q <= IRQ_MASK_RESET;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            tickCnt_q <= tickCnt_d;
            attachSense_q <= attachSense;
            holdCnt_q <= holdCnt_d;
            cdpQual_q <= cdpQual_d;
            safe_q <= safe_d;
            safeCnt_q <= safeCnt_d;
            flag_q <= flag_d;
            faultCnt_q <= faultCnt_d;
            fault_q <= fault_d;
            chargingReq_q <= chargingReq;
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_b);

    dcp_flag_a: assert property (enable && isDcp && currentAbove && !chargeStop |=> chargeAttachOe)
        else $error("dedicated mode current did not pull the flag");
    cdp_qual_a: assert property (enable && isCdp && !cdpQual_q && !holdActive |=> !chargeAttachOe)
        else $error("cdp flag without prior handshake");
    safety_stop_a: assert property (safe_q == SAFE_TIMING && safeCnt_q == 32'(SAFETY_LEN) && safeAllowed
        |=> chargeStop && !powerSwitchOn)
        else $error("expired timer did not stop charging");
    timer_start_a: assert property ($rose(safe_q == SAFE_TIMING) |-> $past(attachEvent))
        else $error("safety timer started without attach");
    timer_off_a: assert property (!attachEn |=> safe_q == SAFE_IDLE)
        else $error("attach enable low left the timer running");
    flag_release_a: assert property (!currentAbove && !holdActive && !attachEvent |=> !chargeAttachOe)
        else $error("flag held without current or attach");
    detector_gate_a: assert property (attachDetectorOn == (attachEn && !enable))
        else $error("attach detector gating wrong");
    hold_load_a: assert property (attachEvent |=> holdCnt_q == 32'(HOLD_LEN) ##1 chargeAttachOe)
        else $error("attach hold not started");
    enable_off_a: assert property (!enable |-> !powerSwitchOn && !dataSwitchOn && !emulatorOn)
        else $error("switches on while disabled");
    fault_glitch_a: assert property ($rose(faultOe) |-> $past(faultRaw, 1) && $past(faultRaw, 2))
        else $error("fault output passed a glitch");
    open_drain_a: assert property (chargeAttachOut == 1'b0 && faultOut == 1'b0)
        else $error("open drain output driven high");
    profile_map_a: assert property ({profileSelect2, profileSelect1, profileSelect0} == 3'h7 |-> isCdp)
        else $error("profile 111 not decoded as cdp");

    attach_hold_c: cover property (attachEvent ##1 holdActive);
    cdp_charge_c: cover property (isCdp && cdpQual_q && currentAbove ##1 chargeAttachOe);
    timer_expire_c: cover property (safe_q == SAFE_TIMING ##1 safe_q == SAFE_EXPIRED);
    fault_report_c: cover property ($rose(faultOe));

endmodule

`default_nettype wire

// >>> verif/host_ec_model.sv
// host embedded controller model: control levels and board pull-ups
// assumes changes are made right after clk rises; flag and fault pins pulled up
`timescale 1ns/1ps
`default_nettype none

module host_ec_model (
    input wire logic clk,
    input wire logic flagOe,
    input wire logic flagOut,
    input wire logic faultOe,
    input wire logic faultOut,
    output var logic enable,
    output var logic [2:0] profile,
    output var logic attachEn,
    output var logic sleepS45,
    output var logic hostOnBattery,
    output wire logic flagPin,
    output wire logic faultPin,
    output var logic converterOn
);
    // a released open-drain pin reads the pull-up level, never the last driven value
    assign flagPin = flagOe ? flagOut : 1'b1;
    assign faultPin = faultOe ? faultOut : 1'b1;

    initial begin
        enable = 1'b0;
        profile = 3'h0;
        attachEn = 1'b0;
        sleepS45 = 1'b0;
        hostOnBattery = 1'b0;
        converterOn = 1'b1;
    end

    // optional power saving: drop the big converter once the flag releases
    always @(posedge clk) converterOn <= !flagPin;

    task automatic setHost(input logic en, input logic [2:0] p, input logic a, input logic s);
        @(posedge clk);
        enable <= en;
        profile <= p;
        attachEn <= a;
        sleepS45 <= s;
        hostOnBattery <= s;
    endtask
endmodule

`default_nettype wire

// >>> verif/charge_attach_indicator_control_test.sv
// self-checking bench of the charge/attach indicator control
// assumes shortened tick, hold, safety and deglitch lengths; host side is host_ec_model
`timescale 1ns/1ps
`default_nettype none

module charge_attach_indicator_control_test;
    import charge_attach_pkg::*;
    typedef struct {int sel; logic [31:0] val;} note_s;
    logic clk;
    logic rst_b;
    axi_req_s axiReq;
    axi_rsp_s axiRsp;
    logic currentAbove, handshakeDone, attachSense, dcp;
    logic [2:0] flt;
    logic [2:0] profile;
    logic enable, attachEn, sleepS45, hostOnBattery, flagPin, faultPin;
    logic flagOe, flagOut, faultOe, faultOut, pwrOn, dataOn, emuOn, detOn, stop, irq;
    logic [31:0] busData, got, d;
    logic [1:0] busResp;
    int error_cnt = 0;
    int checked = 0;
    int g;
    note_s notes[$];
    note_s note;
    logic [5:0] modeTab [0:7] = '{MODE_OFF, MODE_DCP_AUTO, MODE_SDP, MODE_OFF,
        MODE_DCP_BC, MODE_DCP_DIV, MODE_SDP, MODE_CDP};
    string names [0:8] = '{"flagPin", "faultPin", "switches", "chargeStop", "irq",
        "detectorOn", "busData", "busResp", "powerSwitchOn"};

    charge_attach_indicator_control #(.TICK_LEN(4), .HOLD_LEN(5), .SAFETY_LEN(10),
        .DEGLITCH_LEN(2)) charge_attach_indicator_control_i (
        .clk(clk), .rst_b(rst_b), .axiReq(axiReq), .axiRsp(axiRsp), .enable(enable),
        .profileSelect0(profile[0]), .profileSelect1(profile[1]),
        .profileSelect2(profile[2]), .attachEn(attachEn), .currentAbove(currentAbove),
        .handshakeDone(handshakeDone), .sleepS45(sleepS45), .hostOnBattery(hostOnBattery),
        .attachSense(attachSense), .overCurrent(flt[0]), .thermalShutdown(flt[1]),
        .reverseCurrent(flt[2]), .chargeAttachOut(flagOut), .chargeAttachOe(flagOe),
        .faultOut(faultOut), .faultOe(faultOe), .powerSwitchOn(pwrOn),
        .dataSwitchOn(dataOn), .emulatorOn(emuOn), .attachDetectorOn(detOn),
        .chargeStop(stop), .irq(irq));

    host_ec_model host_ec_model_i (.clk(clk), .flagOe(flagOe), .flagOut(flagOut),
        .faultOe(faultOe), .faultOut(faultOut), .enable(enable), .profile(profile),
        .attachEn(attachEn), .sleepS45(sleepS45), .hostOnBattery(hostOnBattery),
        .flagPin(flagPin), .faultPin(faultPin), .converterOn());

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] seen(input int s);
        case (s)
            0: return 32'(flagPin);
            1: return 32'(faultPin);
            2: return 32'({pwrOn, dataOn, emuOn});
            3: return 32'(stop);
            4: return 32'(irq);
            5: return 32'(detOn);
            6: return busData;
            7: return 32'(busResp);
            default: return 32'(pwrOn);
        endcase
    endfunction

    // outputs are settled at the falling edge, so notes are judged there
    always @(negedge clk) begin
        while (notes.size() > 0) begin
            note = notes.pop_front();
            got = seen(note.sel);
            checked++;
            if (got !== note.val) begin
                error_cnt++;
                $display("ERROR %s expected %h seen %h", names[note.sel], note.val, got);
            end
        end
    end

    task automatic chk(input int s, input logic [31:0] v);
        notes.push_back('{s, v});
    endtask

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic host(input logic en, input logic [2:0] p, input logic a, input logic s);
        host_ec_model_i.setHost(en, p, a, s);
    endtask

    task automatic drv(input logic cur, input logic hs, input logic att);
        @(posedge clk);
        currentAbove <= cur;
        handshakeDone <= hs;
        attachSense <= att;
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
        logic awHit;
        logic wHit;
        logic bHit;
        @(posedge clk);
        axiReq.awaddr <= a;
        axiReq.wdata <= v;
        axiReq.wstrb <= 4'hf;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        bHit = 1'b0;
        while (!bHit) begin
            @(negedge clk);
            awHit = axiReq.awvalid && axiRsp.awready;
            wHit = axiReq.wvalid && axiRsp.wready;
            bHit = axiRsp.bvalid;
            busResp = axiRsp.bresp;
            @(posedge clk);
            if (awHit) axiReq.awvalid <= 1'b0;
            if (wHit) axiReq.wvalid <= 1'b0;
        end
        axiReq.bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a);
        logic arHit;
        logic rHit;
        @(posedge clk);
        axiReq.araddr <= a;
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        rHit = 1'b0;
        while (!rHit) begin
            @(negedge clk);
            arHit = axiReq.arvalid && axiRsp.arready;
            rHit = axiRsp.rvalid;
            busData = axiRsp.rdata;
            busResp = axiRsp.rresp;
            @(posedge clk);
            if (arHit) axiReq.arvalid <= 1'b0;
        end
        axiReq.rready <= 1'b0;
    endtask

    task automatic results();
        if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // the whole run needs a few hundred cycles; this leaves ample margin
    initial begin
        waitCyc(20000);
        error_cnt++;
        results();
    end

    initial begin
        rst_b = 1'b0;
        axiReq = '0;
        currentAbove = 1'b0;
        handshakeDone = 1'b0;
        attachSense = 1'b0;
        flt = 3'h0;
        void'($urandom(32'h339f_1e90));
        waitCyc(5);
        rst_b <= 1'b1;
        waitCyc(4);
        axiRead(IRQ_MASK_OFS);
        chk(6, 32'(IRQ_MASK_RESET));
        axiRead(8'h0c);
        chk(7, 32'(RESP_SLVERR));
        d = $urandom;
        axiWrite(IRQ_MASK_OFS, d);
        axiRead(IRQ_MASK_OFS);
        chk(6, d & 32'h0000_000f);
        axiWrite(IRQ_MASK_OFS, 32'h0000_0000);
        drv(1'b1, 1'b0, 1'b0);
        for (int c = 0; c < 8; c++) begin
            dcp = (c == 1 || c == 4 || c == 5);
            host(1'b1, c[2:0], 1'b0, 1'b0);
            waitCyc(3);
            chk(0, 32'(!dcp));
            chk(2, 32'h0000_0006 | 32'(modeTab[c] != MODE_OFF));
            axiRead(STATUS_OFS);
            chk(6, (32'(modeTab[c]) << ST_MODE_LSB) | 32'(dcp));
        end
        host(1'b1, 3'h1, 1'b0, 1'b0);
        waitCyc(3);
        drv(1'b0, 1'b0, 1'b0);
        waitCyc(2);
        chk(0, 1);
        host(1'b1, 3'h7, 1'b0, 1'b0);
        drv(1'b0, 1'b1, 1'b0);
        waitCyc(2);
        drv(1'b1, 1'b0, 1'b0);
        waitCyc(3);
        chk(0, 0);
        drv(1'b0, 1'b0, 1'b0);
        host(1'b1, 3'h6, 1'b0, 1'b0);
        host(1'b1, 3'h7, 1'b0, 1'b0);
        drv(1'b1, 1'b0, 1'b0);
        waitCyc(2);
        drv(1'b1, 1'b1, 1'b0);
        waitCyc(3);
        chk(0, 1);
        drv(1'b0, 1'b0, 1'b0);
        host(1'b0, 3'h1, 1'b1, 1'b0);
        waitCyc(2);
        chk(2, 0);
        chk(5, 1);
        host(1'b1, 3'h1, 1'b1, 1'b0);
        drv(1'b0, 1'b0, 1'b1);
        waitCyc(3);
        chk(5, 0);
        chk(0, 1);
        host(1'b0, 3'h1, 1'b1, 1'b0);
        drv(1'b0, 1'b0, 1'b0);
        waitCyc(2);
        drv(1'b0, 1'b0, 1'b1);
        waitCyc(3);
        chk(0, 0);
        waitCyc(8);
        chk(0, 0);
        waitCyc(20);
        chk(0, 1);
        drv(1'b0, 1'b0, 1'b0);
        host(1'b0, 3'h1, 1'b1, 1'b1);
        waitCyc(60);
        chk(3, 0);
        drv(1'b0, 1'b0, 1'b1);
        host(1'b1, 3'h1, 1'b1, 1'b1);
        drv(1'b1, 1'b0, 1'b1);
        waitCyc(3);
        chk(0, 0);
        waitCyc(60);
        chk(3, 1);
        chk(8, 0);
        chk(0, 1);
        host(1'b1, 3'h1, 1'b0, 1'b1);
        waitCyc(3);
        chk(3, 0);
        drv(1'b0, 1'b0, 1'b0);
        host(1'b0, 3'h1, 1'b1, 1'b1);
        drv(1'b0, 1'b0, 1'b1);
        waitCyc(10);
        host(1'b0, 3'h1, 1'b0, 1'b1);
        drv(1'b0, 1'b0, 1'b0);
        host(1'b1, 3'h1, 1'b1, 1'b1);
        waitCyc(60);
        chk(3, 0);
        for (int s = 0; s < 3; s++) begin
            g = 1 + $urandom % 3;
            flt[s] <= 1'b1;
            waitCyc(g);
            flt[s] <= 1'b0;
            waitCyc(3);
            chk(1, 1);
            flt[s] <= 1'b1;
            waitCyc(25);
            chk(1, 0);
            flt[s] <= 1'b0;
            waitCyc(3);
            chk(1, 1);
        end
        axiRead(IRQ_STATUS_OFS);
        chk(6, 32'h0000_000f);
        chk(4, 0);
        axiWrite(IRQ_MASK_OFS, 32'h0000_0004);
        waitCyc(1);
        chk(4, 1);
        axiWrite(IRQ_STATUS_OFS, 32'h0000_000f);
        waitCyc(1);
        chk(4, 0);
        flt[0] <= 1'b1;
        waitCyc(25);
        chk(4, 1);
        flt[0] <= 1'b0;
        axiWrite(IRQ_MASK_OFS, 32'h0000_0000);
        waitCyc(1);
        chk(4, 0);
        waitCyc(3);
        results();
    end
endmodule

`default_nettype wire
